// File: twmr_pkg.sv
// package: register map, field positions, status codes and timing for the two-wire master receiver
package twmr_pkg;

  // register byte addresses (chosen map, one aligned word each)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;
  localparam logic [7:0] ADDR_OWN     = 8'h0c;
  localparam logic [7:0] ADDR_DIVIDER = 8'h10;

  // control register bit positions
  localparam int CTL_JOB_DONE  = 7;
  localparam int CTL_ACK_EN    = 6;
  localparam int CTL_START_REQ = 5;
  localparam int CTL_STOP_REQ  = 4;
  localparam int CTL_WCOL      = 3;
  localparam int CTL_ENABLE    = 2;
  localparam int CTL_IRQ_EN    = 0;

  localparam int STATUS_PRESC_W = 2;

  // status codes, prescaler bits zero
  localparam logic [4:0] ST_START      = 5'h01; // 0x08
  localparam logic [4:0] ST_RESTART    = 5'h02; // 0x10
  localparam logic [4:0] ST_MT_MODE    = 5'h03; // 0x18, handed to the transmitter
  localparam logic [4:0] ST_ARB_LOST   = 5'h07; // 0x38
  localparam logic [4:0] ST_ADDR_ACK   = 5'h08; // 0x40
  localparam logic [4:0] ST_ADDR_NACK  = 5'h09; // 0x48
  localparam logic [4:0] ST_DATA_ACK   = 5'h0a; // 0x50
  localparam logic [4:0] ST_DATA_NACK  = 5'h0b; // 0x58
  localparam logic [4:0] ST_IDLE       = 5'h1f; // 0xf8

  localparam logic [7:0] GENERAL_CALL  = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h0f;
  localparam logic [7:0] OWN_RESET     = 8'hfe;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // bus time for a quarter bit at 100 kHz, in ns, and the cycles it takes at 10 ns
  localparam int CLK_PERIOD_NS  = 10;
  localparam int QUARTER_NS     = 2500;
  localparam int QUARTER_CYCLES = QUARTER_NS / CLK_PERIOD_NS;

  localparam logic [31:0] HRDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } twmr_pins_in_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twmr_pins_out_type;

endpackage : twmr_pkg

// File: twmr_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/10ps
`default_nettype none
module twmr_sync
  import twmr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire twmr_pins_in_type pins_i,
  output var  twmr_pins_in_type pins_o
);
  twmr_pins_in_type meta_q;
  twmr_pins_in_type meta_d;
  twmr_pins_in_type sync_q;
  twmr_pins_in_type sync_d;

  always_comb
  begin
    meta_d = pins_i;
    sync_d = meta_q;
  end

  // idle bus is high, so reset to high keeps false edges away
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins_o = sync_q;
endmodule // twmr_sync
`default_nettype wire

// File: twmr_core.sv
// two-wire master receiver with ahb-lite register slave
// How it works
// - master mode follows a start; read bit selects receiver, write bit transmitter
// - status codes assume prescaler bits zero; software masks them
// - start waits until the bus is free
// - after start, flag set with status 0x08
// - after the address and its acknowledge, flag set with 0x18, 0x38, 0x40 or 0x48
// - received byte is readable in the data register while the flag is set
// - repeated start reports 0x10 and keeps the bus
// - in 0x10 the loaded address is sent; write bit hands over to transmitter
// - arbitration loss: release bus, or start again once the bus frees
// - in 0x40 or 0x50 clearing the flag receives a byte, ack per ack enable
// - in 0x48 or 0x58: start gives restart, stop gives stop, both give stop then start
// - sending a stop clears the stop request by itself
// - 0x58 keeps the nack byte readable until software decides
// - own address register top seven bits hold the slave address
// - general call 0x00 answered while the general call enable bit is one, or when the own address top seven bits are zero
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module twmr_core
  import twmr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  input  wire twmr_pins_in_type  pins_i,
  output var  twmr_pins_out_type pins_o,
  output var  logic              addressed_q
);

  typedef enum {S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_BIT, S_STOP} twmr_state_type;

  twmr_pins_in_type pins_s;

  twmr_sync u_sync (
    .clk    (clk),
    .reset  (reset),
    .pins_i (pins_i),
    .pins_o (pins_s)
  );

  // bus slave address phase capture
  logic       wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;

  // registers
  logic [7:0] ctl_q, ctl_d;
  logic [4:0] status_q, status_d;
  logic [7:0] data_q, data_d;
  logic [7:0] own_q, own_d;
  logic [7:0] div_q, div_d;

  // engine
  twmr_state_type state_q, state_d;
  logic [1:0]  phase_q, phase_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  tick_q, tick_d;
  logic        scl_q, scl_d;
  logic        sda_q, sda_d;
  logic        busy_q, busy_d;
  logic        restart_after_q, restart_after_d;
  logic        master_q, master_d;
  logic        addr_q, addr_d;
  logic        addressed_d;
  logic        sda_prev_q, sda_prev_d;
  logic        arb_q, arb_d;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic tick;
  logic sw_clear;
  logic [7:0] wval;
  assign tick = (tick_q == 8'h00);
  assign wval = hwdata[7:0];
  assign sw_clear = wr_pend_q && is_reg(wr_addr_q, ADDR_CONTROL) && wval[CTL_JOB_DONE];

  // bus slave: zero wait states, always okay
  always_comb
  begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    hrdata_d  = HRDATA_ZERO;
    if (hsel && hready && htrans[1])
    begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr[7:0];
      if (!hwrite)
      begin
        if (is_reg(haddr[7:0], ADDR_CONTROL))
          hrdata_d = {24'h00_0000, ctl_q};
        else if (is_reg(haddr[7:0], ADDR_STATUS))
          hrdata_d = {24'h00_0000, status_q, 1'b0, {STATUS_PRESC_W{1'b0}}};
        else if (is_reg(haddr[7:0], ADDR_DATA))
          hrdata_d = {24'h00_0000, data_q};
        else if (is_reg(haddr[7:0], ADDR_OWN))
          hrdata_d = {24'h00_0000, own_q};
        else if (is_reg(haddr[7:0], ADDR_DIVIDER))
          hrdata_d = {24'h00_0000, div_q};
      end
    end
  end

  // engine and register next state
  always_comb
  begin
    ctl_d = ctl_q;
    status_d = status_q;
    data_d = data_q;
    own_d = own_q;
    div_d = div_q;
    state_d = state_q;
    phase_d = phase_q;
    bit_d = bit_q;
    tick_d = tick ? div_q : tick_q - 8'h01;
    scl_d = scl_q;
    sda_d = sda_q;
    restart_after_d = restart_after_q;
    master_d = master_q;
    addr_d = addr_q;
    addressed_d = addressed_q;
    arb_d = arb_q;
    sda_prev_d = pins_s.sda_i;
    busy_d = busy_q;
    // start and stop seen on the wires track bus occupancy
    if (pins_s.scl_i && sda_prev_q && !pins_s.sda_i)
      busy_d = 1'b1;
    else if (pins_s.scl_i && !sda_prev_q && pins_s.sda_i)
      busy_d = 1'b0;

    if (wr_pend_q)
    begin
      if (is_reg(wr_addr_q, ADDR_CONTROL))
      begin
        ctl_d[CTL_ACK_EN] = wval[CTL_ACK_EN];
        ctl_d[CTL_START_REQ] = wval[CTL_START_REQ];
        ctl_d[CTL_STOP_REQ] = wval[CTL_STOP_REQ];
        ctl_d[CTL_ENABLE] = wval[CTL_ENABLE];
        ctl_d[CTL_IRQ_EN] = wval[CTL_IRQ_EN];
        // the engine below runs later in this process, so a same-cycle hardware set wins
        if (sw_clear)
          ctl_d[CTL_JOB_DONE] = 1'b0;
      end
      else if (is_reg(wr_addr_q, ADDR_DATA))
      begin
        if (ctl_q[CTL_JOB_DONE])
          data_d = wval;
        else
          ctl_d[CTL_WCOL] = 1'b1;
      end
      else if (is_reg(wr_addr_q, ADDR_OWN))
        own_d = wval;
      else if (is_reg(wr_addr_q, ADDR_DIVIDER))
        div_d = wval;
    end

    if (!ctl_q[CTL_ENABLE])
    begin
      state_d = S_IDLE;
      scl_d = 1'b1;
      sda_d = 1'b1;
      master_d = 1'b0;
      status_d = ST_IDLE;
    end
    else if (tick)
    begin
      case (state_q)
        S_IDLE:
        begin
          if (ctl_q[CTL_START_REQ] && !ctl_q[CTL_JOB_DONE])
            state_d = S_WAIT_FREE;
        end
        S_WAIT_FREE:
        begin
          if (!busy_q || master_q)
          begin
            state_d = S_START;
            phase_d = 2'd0;
          end
        end
        S_START:
        begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            2'd0:
            begin
              sda_d = 1'b1;
              scl_d = 1'b1;
            end
            2'd1: sda_d = 1'b0;
            2'd2: scl_d = 1'b0;
            default:
            begin
              status_d = master_q ? ST_RESTART : ST_START;
              master_d = 1'b1;
              addr_d = 1'b1;
              ctl_d[CTL_JOB_DONE] = 1'b1;
              state_d = S_HOLD;
            end
          endcase
        end
        S_HOLD:
        begin
          scl_d = 1'b0;
          if (!ctl_q[CTL_JOB_DONE])
          begin
            if (status_q == ST_ARB_LOST)
            begin
              master_d = 1'b0;
              sda_d = 1'b1;
              scl_d = 1'b1;
              state_d = ctl_q[CTL_START_REQ] ? S_WAIT_FREE : S_IDLE;
            end
            else if (status_q == ST_ADDR_NACK || status_q == ST_DATA_NACK)
            begin
              if (ctl_q[CTL_STOP_REQ])
              begin
                restart_after_d = ctl_q[CTL_START_REQ];
                state_d = S_STOP;
                phase_d = 2'd0;
              end
              else if (ctl_q[CTL_START_REQ])
              begin
                state_d = S_START;
                phase_d = 2'd0;
              end
            end
            else if (status_q == ST_START || status_q == ST_RESTART || status_q == ST_ADDR_ACK ||
                     status_q == ST_DATA_ACK)
            begin
              bit_d = 4'd0;
              phase_d = 2'd0;
              state_d = S_BIT;
            end
          end
        end
        S_BIT:
        begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            // the address ack bit is released so the slave can answer
            2'd0:
              if (bit_q == 4'd8)
                sda_d = addr_q ? 1'b1 : !ctl_q[CTL_ACK_EN];
              else if (addr_q)
                sda_d = data_q[3'd7 - bit_q[2:0]];
              else
                sda_d = 1'b1;
            2'd1: scl_d = 1'b1;
            // a slave may stretch the clock: sample only once the wire is really high
            2'd2:
              if (!pins_s.scl_i)
                phase_d = phase_q;
              else
              begin
                if (addr_q && bit_q != 4'd8 && sda_q && !pins_s.sda_i)
                  arb_d = 1'b1;
                if (!addr_q && bit_q != 4'd8)
                  data_d = {data_q[6:0], pins_s.sda_i};
                if (addr_q && bit_q == 4'd8)
                  sda_prev_d = pins_s.sda_i;
              end
            default:
            begin
              scl_d = 1'b0;
              bit_d = bit_q + 4'd1;
              if (arb_q)
              begin
                arb_d = 1'b0;
                sda_d = 1'b1;
                status_d = ST_ARB_LOST;
                ctl_d[CTL_JOB_DONE] = 1'b1;
                state_d = S_HOLD;
              end
              else if (bit_q == 4'd8)
              begin
                ctl_d[CTL_JOB_DONE] = 1'b1;
                state_d = S_HOLD;
                if (addr_q)
                begin
                  addr_d = 1'b0;
                  if (!data_q[0])
                    status_d = ST_MT_MODE;
                  else
                    status_d = pins_s.sda_i ? ST_ADDR_NACK : ST_ADDR_ACK;
                end
                else
                  status_d = ctl_q[CTL_ACK_EN] ? ST_DATA_ACK : ST_DATA_NACK;
              end
              else if (bit_q == 4'd7)
                sda_d = addr_q ? 1'b1 : sda_q;
            end
          endcase
        end
        S_STOP:
        begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_d = 1'b0;
            2'd1: scl_d = 1'b1;
            2'd2: sda_d = 1'b1;
            default:
            begin
              ctl_d[CTL_STOP_REQ] = 1'b0;
              master_d = 1'b0;
              status_d = ST_IDLE;
              state_d = restart_after_q ? S_WAIT_FREE : S_IDLE;
              restart_after_d = 1'b0;
            end
          endcase
        end
        default: state_d = S_IDLE;
      endcase
    end

    // own address match watched while not master
    if (!master_q && busy_q && (data_q[7:1] == own_q[7:1]))
      addressed_d = 1'b1;
    else if (!master_q && busy_q && data_q == GENERAL_CALL && own_q[0])
      addressed_d = 1'b1;
    else if (!busy_q)
      addressed_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= HRDATA_ZERO;
      ctl_q <= CONTROL_RESET;
      status_q <= ST_IDLE;
      data_q <= 8'hff;
      own_q <= OWN_RESET;
      div_q <= DIVIDER_RESET;
      state_q <= S_IDLE;
      phase_q <= 2'd0;
      bit_q <= 4'd0;
      tick_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      restart_after_q <= 1'b0;
      master_q <= 1'b0;
      addr_q <= 1'b0;
      addressed_q <= 1'b0;
      sda_prev_q <= 1'b1;
      arb_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      ctl_q <= ctl_d;
      status_q <= status_d;
      data_q <= data_d;
      own_q <= own_d;
      div_q <= div_d;
      state_q <= state_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      tick_q <= tick_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      busy_q <= busy_d;
      restart_after_q <= restart_after_d;
      master_q <= master_d;
      addr_q <= addr_d;
      addressed_q <= addressed_d;
      sda_prev_q <= sda_prev_d;
      arb_q <= arb_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // open drain: drive only lows
  assign pins_o = '{scl_o: 1'b0, scl_oe: !scl_q, sda_o: 1'b0, sda_oe: !sda_q};

  property p_hold_low;
    @(posedge clk) disable iff (reset)
    (state_q == S_HOLD && ctl_q[CTL_JOB_DONE] && ctl_q[CTL_ENABLE]) |=> !scl_q;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held low while flag set");

  property p_stop_clears;
    @(posedge clk) disable iff (reset)
    (state_q == S_STOP && tick && phase_q == 2'd3 && ctl_q[CTL_ENABLE]) |=> !ctl_q[CTL_STOP_REQ];
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop request not cleared");

  property p_start_status;
    @(posedge clk) disable iff (reset)
    (state_q == S_START && tick && phase_q == 2'd3 && !master_q && ctl_q[CTL_ENABLE])
      |=> (status_q == ST_START && ctl_q[CTL_JOB_DONE]);
  endproperty
  a_start_status: assert property (p_start_status) else $error("start status wrong");

  property p_wait_busy;
    @(posedge clk) disable iff (reset)
    (state_q == S_WAIT_FREE && busy_q && !master_q) |=> state_q != S_START;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("start on busy bus");

  property p_restart_status;
    @(posedge clk) disable iff (reset)
    (state_q == S_START && tick && phase_q == 2'd3 && master_q && ctl_q[CTL_ENABLE])
      |=> status_q == ST_RESTART;
  endproperty
  a_restart_status: assert property (p_restart_status) else $error("restart status wrong");

  property p_ack_drive;
    @(posedge clk) disable iff (reset)
    (state_q == S_BIT && !addr_q && bit_q == 4'd8 && phase_q == 2'd0 && tick && ctl_q[CTL_ENABLE])
      |=> sda_q == !$past(ctl_q[CTL_ACK_EN]);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack level wrong");

  property p_data_stable;
    @(posedge clk) disable iff (reset)
    (status_q == ST_DATA_NACK && ctl_q[CTL_JOB_DONE] && !wr_pend_q) |=> $stable(data_q);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("received byte changed");

  property p_addr_status;
    @(posedge clk) disable iff (reset)
    $rose(ctl_q[CTL_JOB_DONE]) && $past(addr_q) && !addr_q && $past(data_q[0])
      |-> (status_q == ST_ADDR_ACK || status_q == ST_ADDR_NACK || status_q == ST_ARB_LOST);
  endproperty
  a_addr_status: assert property (p_addr_status) else $error("address status wrong");

endmodule // twmr_core
`default_nettype wire

// File: twmr_slave_model.sv
// behavioural slave transmitter that sits on the far side of the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module twmr_slave_model
  import twmr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic       slow,
  output var  logic       scl_low,
  output var  logic       sda_low
);
  logic       scl_q, sda_q, act_q, data_q, mack_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [4:0] hold_q;

  // slow mode stretches every low phase of the clock
  assign scl_low = (hold_q != 5'h0);

  always @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold_q != 5'h0)
      hold_q <= hold_q - 5'h1;
    if (reset)
    begin
      act_q   <= 1'b0;
      sda_low <= 1'b0;
      hold_q  <= 5'h0;
    end
    else if (scl && scl_q && (sda != sda_q))
    begin
      // start (sda falls) or stop (sda rises) while the clock is high
      act_q   <= !sda;
      data_q  <= 1'b0;
      cnt_q   <= 4'h0;
      sda_low <= 1'b0;
    end
    else if (act_q && scl && !scl_q)
    begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q < 4'h8 && !data_q)
        sh_q <= {sh_q[6:0], sda};
      if (cnt_q == 4'h8)
        mack_q <= !sda;
    end
    else if (act_q && !scl && scl_q)
    begin
      if (slow)
        hold_q <= 5'd24;
      if (cnt_q == 4'h8)
        sda_low <= !data_q && (sh_q[7:1] == SLAVE_ADDR);
      else if (cnt_q == 4'h9)
      begin
        cnt_q <= 4'h0;
        // a nack from the master ends the transfer and frees the data line
        if ((data_q && mack_q) || (!data_q && sh_q[7:1] == SLAVE_ADDR && sh_q[0]))
        begin
          data_q  <= 1'b1;
          sh_q    <= tx_byte;
          sda_low <= !tx_byte[7];
        end
        else
        begin
          act_q   <= 1'b0;
          sda_low <= 1'b0;
        end
      end
      else if (data_q && cnt_q != 4'h0)
      begin
        sda_low <= !sh_q[6];
        sh_q    <= {sh_q[6:0], 1'b0};
      end
    end
  end
endmodule // twmr_slave_model
`default_nettype wire

// File: test_two_wire_master_receiver.sv
// self-checking testbench of the two-wire master receiver core
`timescale 1ns/10ps
`default_nettype none
module test_two_wire_master_receiver
  import twmr_pkg::*;
();
  localparam logic [6:0] SLV    = 7'h2a;
  localparam logic [7:0] NO_REG = 8'h14;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0000_0000;
  logic [1:0]        htrans = 2'b00;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'b010;
  logic [31:0]       hwdata = 32'h0000_0000;
  logic              hready, hreadyout, hresp, addressed_q, rd_ph = 1'b0;
  logic [31:0]       hrdata;
  twmr_pins_in_type  pins_in;
  twmr_pins_out_type pins_out;
  logic              scl_w, sda_w, slv_scl_low, slv_sda_low;
  logic              ext_low = 1'b0;
  logic              slow = 1'b0;
  logic [7:0]        tx_byte = 8'h00;
  logic [7:0]        b[5];
  logic [64:0]       exp_q[$];
  int                bad_count = 0;
  int                n_compared = 0;
  int                ticks = 0;

  always #5 clk = ~clk;
  assign hready  = hreadyout;
  // open-drain wires with pull-ups: low while any party pulls
  assign scl_w   = !pins_out.scl_oe && !slv_scl_low;
  assign sda_w   = !pins_out.sda_oe && !slv_sda_low && !ext_low;
  assign pins_in = {scl_w, sda_w};

  twmr_core DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pins_i(pins_in), .pins_o(pins_out), .addressed_q(addressed_q));
  twmr_slave_model #(.SLAVE_ADDR(SLV)) partner (.clk(clk), .reset(reset), .scl(scl_w), .sda(sda_w),
    .tx_byte(tx_byte), .slow(slow), .scl_low(slv_scl_low), .sda_low(slv_sda_low));

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: wire level %b, expected %b", $time, got, exp);
    end
  endtask

  // one single transfer; a read notes {check, mask, value} for the monitor
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [64:0] ex,
                      output logic [31:0] rd);
    if (!w)
      exp_q.push_back(ex);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h00_0000, d}, '0, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, {1'b1, m, e}, r);
  endtask

  // the first read may overlap a preceding write, so it is thrown away
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, '0, r);
    r = ~v;
    while ((r & m) !== v)
      xfer(1'b0, a, 32'h0000_0000, '0, r);
  endtask

  task automatic go(input logic ld, input logic [7:0] d, input logic [7:0] ctl, input logic [4:0] code);
    if (ld)
      wr(ADDR_DATA, d);
    wr(ADDR_CONTROL, ctl);
    poll(ADDR_CONTROL, 32'h0000_0080, 32'h0000_0080);
    rdc(ADDR_STATUS, 32'h0000_00f8, {24'h00_0000, code, 3'b000});
  endtask

  // another master's start makes the bus busy while this one is idle
  task automatic ext_addr(input logic [7:0] own, input logic exp);
    wr(ADDR_OWN, own);
    ext_low <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_bit(addressed_q, exp);
    ext_low <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      if (exp_q[0][64])
        cmp_reg(hrdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    if (hready === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite;
  end

  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 40000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(32'h1f0a_b8c3));
    foreach (b[i])
      b[i] = 8'($urandom());
    tx_byte = b[0];
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(ADDR_CONTROL, 32'hffff_ffff, {24'h00_0000, CONTROL_RESET});
    rdc(ADDR_STATUS, 32'hffff_ffff, {24'h00_0000, ST_IDLE, 3'b000});
    rdc(ADDR_OWN, 32'hffff_ffff, {24'h00_0000, OWN_RESET});
    rdc(ADDR_DIVIDER, 32'hffff_ffff, {24'h00_0000, DIVIDER_RESET});
    wr(NO_REG, 8'hff);
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_OWN, {SLV, 1'b1});
    // quarter bit of four cycles gives a 160 ns bus clock
    wr(ADDR_DIVIDER, 8'h03);
    rdc(ADDR_CONTROL, 32'h0000_0008, 32'h0000_0008);
    rdc(ADDR_OWN, 32'hffff_ffff, {24'h00_0000, SLV, 1'b1});
    rdc(ADDR_DIVIDER, 32'hffff_ffff, 32'h0000_0003);
    rdc(NO_REG, 32'hffff_ffff, 32'h0000_0000);
    $display("test registers done");
    // another master holds the bus with its own start
    ext_low <= 1'b1;
    repeat (20) @(posedge clk);
    wr(ADDR_CONTROL, 8'ha4);
    repeat (300) @(posedge clk);
    rdc(ADDR_CONTROL, 32'h0000_0080, 32'h0000_0000);
    ext_low <= 1'b0;
    go(1'b0, 8'h00, 8'ha4, ST_START);
    cmp_bit(addressed_q, 1'b0);
    go(1'b1, {7'h13, 1'b1}, 8'h84, ST_ADDR_NACK);
    go(1'b0, 8'h00, 8'ha4, ST_RESTART);
    go(1'b1, {SLV, 1'b1}, 8'h84, ST_ADDR_ACK);
    $display("test start and address done");
    for (int j = 0; j < 4; j++)
    begin
      tx_byte <= b[j + 1];
      slow    <= (j == 1);
      go(1'b0, 8'h00, (j < 3) ? 8'hc4 : 8'h84, (j < 3) ? ST_DATA_ACK : ST_DATA_NACK);
      repeat (40) @(posedge clk);
      cmp_bit(scl_w, 1'b0);
      rdc(ADDR_DATA, 32'h0000_00ff, {24'h00_0000, b[j]});
    end
    slow <= 1'b0;
    $display("test receive done");
    // the flag is still set, so the data register takes the general call byte for the idle tests
    wr(ADDR_DATA, GENERAL_CALL);
    wr(ADDR_CONTROL, 8'h94);
    poll(ADDR_CONTROL, 32'h0000_0010, 32'h0000_0000);
    repeat (64) @(posedge clk);
    cmp_bit(scl_w & sda_w, 1'b1);
    rdc(ADDR_STATUS, 32'h0000_00f8, 32'h0000_00f8);
    ext_addr({SLV, 1'b0}, 1'b0);
    ext_addr({SLV, 1'b1}, 1'b1);
    ext_addr({7'h00, 1'b0}, 1'b1);
    $display("test own address done");
    go(1'b0, 8'h00, 8'ha4, ST_START);
    go(1'b1, {SLV, 1'b1}, 8'h84, ST_ADDR_ACK);
    go(1'b0, 8'h00, 8'h84, ST_DATA_NACK);
    rdc(ADDR_DATA, 32'h0000_00ff, {24'h00_0000, b[4]});
    go(1'b0, 8'h00, 8'hb4, ST_START);
    rdc(ADDR_CONTROL, 32'h0000_0090, 32'h0000_0080);
    go(1'b1, {7'h13, 1'b1}, 8'h84, ST_ADDR_NACK);
    go(1'b0, 8'h00, 8'ha4, ST_RESTART);
    go(1'b1, {SLV, 1'b0}, 8'h84, ST_MT_MODE);
    $display("test stop and restart done");
    conclude();
  end
endmodule // test_two_wire_master_receiver
`default_nettype wire
